// ### inc/vtd_regs.vh
// register offsets, field positions, reset values and widths of the timing detector
`ifndef VTD_REGS_VH
`define VTD_REGS_VH
// apb byte offsets
`define VTD_CTRL_OFS 12'h000
`define VTD_STATUS_OFS 12'h004
`define VTD_TOTAL_COLS_OFS 12'h008
`define VTD_TOTAL_ROWS_OFS 12'h00c
`define VTD_BLANK_ROWS_OFS 12'h010
`define VTD_BLANK_LEFT_OFS 12'h014
`define VTD_BLANK_RIGHT_OFS 12'h018
`define VTD_ACT_LEFT_OFS 12'h01c
`define VTD_ACT_RIGHT_OFS 12'h020
`define VTD_ACT_TOP_OFS 12'h024
`define VTD_ACT_BOTTOM_OFS 12'h028
`define VTD_GEN_LEFT_OFS 12'h02c
`define VTD_GEN_RIGHT_OFS 12'h030
`define VTD_GEN_TOP_OFS 12'h034
`define VTD_GEN_BOTTOM_OFS 12'h038
// control fields
`define VTD_CTRL_HPOL_BIT 0
`define VTD_CTRL_VPOL_BIT 1
`define VTD_CTRL_AUTO_BIT 2
`define VTD_CTRL_GEN_BIT 3
`define VTD_CTRL_RST 32'h0000_0004
// status fields
`define VTD_ST_HPOL_BIT 0
`define VTD_ST_VPOL_BIT 1
`define VTD_ST_HSEEN_BIT 2
`define VTD_ST_VSEEN_BIT 3
`define VTD_ST_LOCK_BIT 4
// counter widths
`define VTD_CW 32
`define VTD_DW 16
`define VTD_DIV_STEPS 32
`endif

// ### src/vtd_divider.v
// sequential unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
module vtd_divider
(
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire [31:0] dividend,
  input wire [15:0] divisor,
  output reg [15:0] quotient,
  output reg done
);
  // restoring division keeps area small; 32 cycles per result
  reg [31:0] num_reg;
  reg [32:0] rem_reg;
  reg [15:0] den_reg;
  reg [5:0] cnt_reg;
  reg busy_reg;
  wire [32:0] trial;
  assign trial = {rem_reg[31:0], num_reg[31]} - {17'h0_0000, den_reg};

  // iterate from msb down
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      num_reg <= 32'h0000_0000;
      rem_reg <= 33'h0_0000_0000;
      den_reg <= 16'h0000;
      cnt_reg <= 6'h00;
      busy_reg <= 1'b0;
      quotient <= 16'h0000;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy_reg)
      begin
        num_reg <= dividend;
        rem_reg <= 33'h0_0000_0000;
        den_reg <= divisor;
        cnt_reg <= 6'h00;
        busy_reg <= 1'b1;
      end
      else if (busy_reg)
      begin
        num_reg <= {num_reg[30:0], 1'b0};
        // non-negative trial keeps the subtraction
        if (!trial[32])
        begin
          rem_reg <= trial;
          num_reg <= {num_reg[30:0], 1'b1};
        end
        else
          rem_reg <= {rem_reg[31:0], num_reg[31]};
        cnt_reg <= cnt_reg + 6'h01;
        if (cnt_reg == 6'h1f)
        begin
          busy_reg <= 1'b0;
          done <= 1'b1;
          // quotient bits shifted into num; saturate to 16 bits
          // upper quotient half sits in num_reg[30:15] on the last step
          quotient <= (num_reg[30:15] != 16'h0000) ? 16'hffff :
            {num_reg[14:0], ~trial[32]};
        end
      end
    end
  end
endmodule

// ### src/vtd_top.v
// input video timing detector with re-framing generator and apb registers
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "vtd_regs.vh"

// Functional notes
// - active sample while blank high: valid style
// - active sample while blank low: blank style
// - active sample flag always active high
// - vblank fall is frame origin, rise blanks
// - hblank rise starts, fall ends blanking
// - width is cycles between hblank falls
// - rows are vblank period over width
// - blank rows: vblank high time over width
// - left blank: vblank fall to hblank fall
// - right blank: vblank fall to hblank rise
// - first active sample gives top and left
// - last active sample gives bottom and right
// - all measurements readable over the bus
// - generator re-frames, moves blanking, crops active
// - re-framing keeps size and pixel rate
// - polarity bit1 vertical, bit0 horizontal, 1 valid
module vtd_top
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire hblank_in,
  input wire vblank_in,
  input wire active_video_in,
  input wire [11:0] video_data_in,
  output reg hblank_out,
  output reg vblank_out,
  output reg active_video_out,
  output reg [11:0] video_data_out
);
  // pin synchronisers: stage one feeds only stage two
  reg [2:0] sync1_reg;
  reg [2:0] sync2_reg;
  reg [11:0] data1_reg;
  reg [11:0] data2_reg;
  // previous normalised levels for edge detection
  reg hb_d_reg;
  reg vb_d_reg;
  // registers
  reg [31:0] ctrl_reg;
  reg hpol_reg;
  reg vpol_reg;
  reg hseen_reg;
  reg vseen_reg;
  reg lock_reg;
  reg [15:0] total_cols_reg;
  reg [15:0] total_rows_reg;
  reg [15:0] blank_rows_reg;
  reg [15:0] blank_left_reg;
  reg [15:0] blank_right_reg;
  reg [15:0] act_left_reg;
  reg [15:0] act_right_reg;
  reg [15:0] act_top_reg;
  reg [15:0] act_bottom_reg;
  reg [15:0] gen_left_reg;
  reg [15:0] gen_right_reg;
  reg [15:0] gen_top_reg;
  reg [15:0] gen_bottom_reg;
  // running counters
  reg [15:0] line_cnt_reg;
  reg [31:0] frame_cnt_reg;
  reg [31:0] vbl_cnt_reg;
  reg [15:0] col_reg;
  reg [15:0] row_reg;
  reg left_open_reg;
  reg right_open_reg;
  reg first_act_reg;
  // per-frame active extent, published at frame start
  reg [15:0] ext_l_reg;
  reg [15:0] ext_r_reg;
  reg [15:0] ext_t_reg;
  reg [15:0] ext_b_reg;
  // divider job select: 0 total rows, 1 blank rows
  reg div_sel_reg;
  reg div_start_reg;
  reg idle_reg; // divider free for a new job
  reg [31:0] div_num_reg;
  reg pend_rows_reg;
  reg pend_blank_reg;
  reg [31:0] pend_rows_num_reg;
  reg [31:0] pend_blank_num_reg;
  wire [15:0] div_q;
  wire div_done;

  wire hb_raw;
  wire vb_raw;
  wire av_in;
  wire use_auto;
  wire hpol_eff;
  wire vpol_eff;
  wire hb_n;
  wire vb_n;
  wire h_fall;
  wire h_rise;
  wire v_fall;
  wire v_rise;
  wire bus_wr;
  wire bus_rd;

  assign hb_raw = sync2_reg[0];
  assign vb_raw = sync2_reg[1];
  assign av_in = sync2_reg[2];
  assign use_auto = ctrl_reg[`VTD_CTRL_AUTO_BIT];
  // polarity 1 means valid style (high = active area)
  assign hpol_eff = use_auto ? hpol_reg : ctrl_reg[`VTD_CTRL_HPOL_BIT];
  assign vpol_eff = use_auto ? vpol_reg : ctrl_reg[`VTD_CTRL_VPOL_BIT];
  assign hb_n = hb_raw ^ hpol_eff;
  assign vb_n = vb_raw ^ vpol_eff;
  assign h_fall = hb_d_reg & ~hb_n;
  assign h_rise = ~hb_d_reg & hb_n;
  assign v_fall = vb_d_reg & ~vb_n;
  assign v_rise = ~vb_d_reg & vb_n;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign bus_wr = psel & penable & pwrite;
  assign bus_rd = psel & ~penable & ~pwrite;

  // width-limiting helper for 32-bit counts into 16-bit fields
  function [15:0] sat16;
    input [31:0] v;
    begin
      sat16 = (v[31:16] != 16'h0000) ? 16'hffff : v[15:0];
    end
  endfunction

  // two flip-flops on every video input pin
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      data1_reg <= 12'h000;
      data2_reg <= 12'h000;
    end
    else
    begin
      sync1_reg <= {active_video_in, vblank_in, hblank_in};
      sync2_reg <= sync1_reg;
      data1_reg <= video_data_in;
      data2_reg <= data1_reg;
    end
  end

  // polarity detection from active samples
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hpol_reg <= 1'b0;
      vpol_reg <= 1'b0;
      hseen_reg <= 1'b0;
      vseen_reg <= 1'b0;
    end
    else if (av_in)
    begin
      // level seen under an active sample tells the style
      hpol_reg <= hb_raw;
      vpol_reg <= vb_raw;
      hseen_reg <= 1'b1;
      vseen_reg <= 1'b1;
    end
  end

  // edge-based measurement counters
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hb_d_reg <= 1'b0;
      vb_d_reg <= 1'b0;
      line_cnt_reg <= 16'h0000;
      frame_cnt_reg <= 32'h0000_0000;
      vbl_cnt_reg <= 32'h0000_0000;
      col_reg <= 16'h0000;
      row_reg <= 16'h0000;
      left_open_reg <= 1'b0;
      right_open_reg <= 1'b0;
      total_cols_reg <= 16'h0000;
      blank_left_reg <= 16'h0000;
      blank_right_reg <= 16'h0000;
      lock_reg <= 1'b0;
      pend_rows_reg <= 1'b0;
      pend_blank_reg <= 1'b0;
      pend_rows_num_reg <= 32'h0000_0000;
      pend_blank_num_reg <= 32'h0000_0000;
    end
    else
    begin
      hb_d_reg <= hb_n;
      vb_d_reg <= vb_n;
      // cycles between successive hblank falls
      if (h_fall)
      begin
        total_cols_reg <= line_cnt_reg + 16'h0001;
        line_cnt_reg <= 16'h0000;
      end
      else
        line_cnt_reg <= line_cnt_reg + 16'h0001;
      // coordinates of the visible sample, lines wrap on the width
      if (v_fall)
      begin
        col_reg <= 16'h0001;
        row_reg <= 16'h0000;
      end
      else if (col_reg >= total_cols_reg - 16'h0001)
      begin
        col_reg <= 16'h0000;
        row_reg <= row_reg + 16'h0001;
      end
      else
        col_reg <= col_reg + 16'h0001;
      // frame period, published at each vblank fall after the first
      if (v_fall)
      begin
        frame_cnt_reg <= 32'h0000_0000;
        pend_rows_num_reg <= frame_cnt_reg + 32'h0000_0001;
        pend_rows_reg <= lock_reg;
        lock_reg <= 1'b1;
      end
      else
      begin
        frame_cnt_reg <= frame_cnt_reg + 32'h0000_0001;
        if (div_start_reg && !div_sel_reg)
          pend_rows_reg <= 1'b0;
      end
      // vertical blank duration, rise to fall
      if (v_rise)
        vbl_cnt_reg <= 32'h0000_0000;
      else if (v_fall)
      begin
        pend_blank_num_reg <= vbl_cnt_reg + 32'h0000_0001;
        pend_blank_reg <= 1'b1;
      end
      else
      begin
        vbl_cnt_reg <= vbl_cnt_reg + 32'h0000_0001;
        if (div_start_reg && div_sel_reg)
          pend_blank_reg <= 1'b0;
      end
      // left and right blank spans after the frame origin
      if (v_fall)
      begin
        left_open_reg <= 1'b1;
        right_open_reg <= 1'b1;
      end
      else
      begin
        if (left_open_reg && h_fall)
        begin
          blank_left_reg <= sat16(frame_cnt_reg + 32'h0000_0001);
          left_open_reg <= 1'b0;
        end
        if (right_open_reg && h_rise)
        begin
          blank_right_reg <= sat16(frame_cnt_reg + 32'h0000_0001);
          right_open_reg <= 1'b0;
        end
      end
    end
  end

  // one shared divider, rows job first
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_start_reg <= 1'b0;
      div_sel_reg <= 1'b0;
      div_num_reg <= 32'h0000_0000;
      total_rows_reg <= 16'h0000;
      blank_rows_reg <= 16'h0000;
    end
    else
    begin
      div_start_reg <= 1'b0;
      if (div_done)
      begin
        if (div_sel_reg)
          blank_rows_reg <= div_q;
        else
          total_rows_reg <= div_q;
      end
      // launch only when idle, width known
      if (!div_start_reg && total_cols_reg != 16'h0000 && idle_reg)
      begin
        if (pend_rows_reg)
        begin
          div_sel_reg <= 1'b0;
          div_num_reg <= pend_rows_num_reg;
          div_start_reg <= 1'b1;
        end
        else if (pend_blank_reg)
        begin
          div_sel_reg <= 1'b1;
          div_num_reg <= pend_blank_num_reg;
          div_start_reg <= 1'b1;
        end
      end
    end
  end

  // divider busy tracking
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idle_reg <= 1'b1;
    else if (div_start_reg)
      idle_reg <= 1'b0;
    else if (div_done)
      idle_reg <= 1'b1;
  end

  vtd_divider u_div
  (
    .pclk(pclk),
    .presetn(presetn),
    .start(div_start_reg),
    .dividend(div_num_reg),
    .divisor(total_cols_reg),
    .quotient(div_q),
    .done(div_done)
  );

  // active extent of the current frame
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_act_reg <= 1'b1;
      ext_l_reg <= 16'h0000;
      ext_r_reg <= 16'h0000;
      ext_t_reg <= 16'h0000;
      ext_b_reg <= 16'h0000;
      act_left_reg <= 16'h0000;
      act_right_reg <= 16'h0000;
      act_top_reg <= 16'h0000;
      act_bottom_reg <= 16'h0000;
    end
    else if (v_fall)
    begin
      // publish last frame's corners, arm next frame
      act_left_reg <= ext_l_reg;
      act_top_reg <= ext_t_reg;
      act_right_reg <= ext_r_reg;
      act_bottom_reg <= ext_b_reg;
      first_act_reg <= 1'b1;
    end
    else if (av_in)
    begin
      if (first_act_reg)
      begin
        ext_l_reg <= col_reg;
        ext_t_reg <= row_reg;
        first_act_reg <= 1'b0;
      end
      // last active sample so far
      ext_r_reg <= col_reg;
      ext_b_reg <= row_reg;
    end
  end

  // re-framing generator: same timing, pixel rate and size
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hblank_out <= 1'b1;
      vblank_out <= 1'b1;
      active_video_out <= 1'b0;
      video_data_out <= 12'h000;
    end
    else if (ctrl_reg[`VTD_CTRL_GEN_BIT])
    begin
      // window rectangle moves blanking and crops active
      hblank_out <= (col_reg < gen_left_reg) || (col_reg > gen_right_reg);
      vblank_out <= (row_reg < gen_top_reg) || (row_reg > gen_bottom_reg);
      active_video_out <= av_in && col_reg >= gen_left_reg &&
        col_reg <= gen_right_reg && row_reg >= gen_top_reg &&
        row_reg <= gen_bottom_reg;
      video_data_out <= data2_reg;
    end
    else
    begin
      // pass-through in normalised polarity, one pixel per clock
      hblank_out <= hb_n;
      vblank_out <= vb_n;
      active_video_out <= av_in;
      video_data_out <= data2_reg;
    end
  end

  // apb writes, take effect in the access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= `VTD_CTRL_RST;
      gen_left_reg <= 16'h0000;
      gen_right_reg <= 16'hffff;
      gen_top_reg <= 16'h0000;
      gen_bottom_reg <= 16'hffff;
    end
    else if (bus_wr)
    begin
      case (paddr)
        `VTD_CTRL_OFS: ctrl_reg <= {28'h000_0000, pwdata[3:0]};
        `VTD_GEN_LEFT_OFS: gen_left_reg <= pwdata[15:0];
        `VTD_GEN_RIGHT_OFS: gen_right_reg <= pwdata[15:0];
        `VTD_GEN_TOP_OFS: gen_top_reg <= pwdata[15:0];
        `VTD_GEN_BOTTOM_OFS: gen_bottom_reg <= pwdata[15:0];
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // apb reads, data captured in setup so it is ready in access
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (bus_rd)
    begin
      case (paddr)
        `VTD_CTRL_OFS: prdata <= ctrl_reg;
        `VTD_STATUS_OFS: prdata <= {27'h000_0000, lock_reg, vseen_reg,
          hseen_reg, vpol_eff, hpol_eff};
        `VTD_TOTAL_COLS_OFS: prdata <= {16'h0000, total_cols_reg};
        `VTD_TOTAL_ROWS_OFS: prdata <= {16'h0000, total_rows_reg};
        `VTD_BLANK_ROWS_OFS: prdata <= {16'h0000, blank_rows_reg};
        `VTD_BLANK_LEFT_OFS: prdata <= {16'h0000, blank_left_reg};
        `VTD_BLANK_RIGHT_OFS: prdata <= {16'h0000, blank_right_reg};
        `VTD_ACT_LEFT_OFS: prdata <= {16'h0000, act_left_reg};
        `VTD_ACT_RIGHT_OFS: prdata <= {16'h0000, act_right_reg};
        `VTD_ACT_TOP_OFS: prdata <= {16'h0000, act_top_reg};
        `VTD_ACT_BOTTOM_OFS: prdata <= {16'h0000, act_bottom_reg};
        `VTD_GEN_LEFT_OFS: prdata <= {16'h0000, gen_left_reg};
        `VTD_GEN_RIGHT_OFS: prdata <= {16'h0000, gen_right_reg};
        `VTD_GEN_TOP_OFS: prdata <= {16'h0000, gen_top_reg};
        `VTD_GEN_BOTTOM_OFS: prdata <= {16'h0000, gen_bottom_reg};
        // unmapped addresses read zero
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ### tb/vtd_top_properties.sv
// port assertions for the timing detector
`timescale 1ns/1ps
`include "vtd_regs.vh"
module vtd_top_properties
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire hblank_in,
  input wire vblank_in,
  input wire active_video_in,
  input wire [11:0] video_data_in,
  input wire hblank_out,
  input wire vblank_out,
  input wire active_video_out,
  input wire [11:0] video_data_out
);
  logic [3:0] ctrl_reg; // shadow of the control word
  logic [2:0] settle_reg; // clocks since reset or control write
  wire ctrl_wr = psel && penable && pwrite && paddr == `VTD_CTRL_OFS;
  wire rd_acc = psel && penable && !pwrite; // read access phase
  // shadow control; settle lets the 3-deep pipe flush old mode
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= 4'h4;
      settle_reg <= 3'h0;
    end
    else if (ctrl_wr)
    begin
      ctrl_reg <= pwdata[3:0];
      settle_reg <= 3'h0;
    end
    else if (settle_reg != 3'h7)
      settle_reg <= settle_reg + 3'h1;
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // generator off and pipe flushed
  sequence pass_mode;
    settle_reg == 3'h7 && !ctrl_reg[3];
  endsequence
  // fixed polarity, no generator
  sequence manual_mode;
    settle_reg == 3'h7 && ctrl_reg[3:2] == 2'b00;
  endsequence
  a_reset_idle: assert property ($rose(presetn) |-> hblank_out &&
    vblank_out && !active_video_out) else $error("outputs not idle");
  a_ready_tied: assert property (pready && !pslverr)
    else $error("apb answer not ready or error");
  a_upper_zero: assert property (rd_acc |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_unmapped_zero: assert property (rd_acc && paddr > 12'h038
    |-> prdata == 32'h0) else $error("unmapped read not zero");
  a_ctrl_readback: assert property (rd_acc && paddr == 12'h000
    |-> prdata[3:0] == ctrl_reg) else $error("control readback wrong");
  a_active_pass: assert property (pass_mode |->
    active_video_out == $past(active_video_in, 3))
    else $error("active flag not passed");
  a_data_pass: assert property (pass_mode |->
    video_data_out == $past(video_data_in, 3))
    else $error("pixel not passed");
  a_hblank_norm: assert property (manual_mode |->
    hblank_out == ($past(hblank_in, 3) ^ ctrl_reg[0]))
    else $error("line blanking level wrong");
  a_vblank_norm: assert property (manual_mode |->
    vblank_out == ($past(vblank_in, 3) ^ ctrl_reg[1]))
    else $error("frame blanking level wrong");
  a_crop_only: assert property (settle_reg == 3'h7 && ctrl_reg[3]
    |-> !active_video_out || $past(active_video_in, 3))
    else $error("generator invented an active sample");
endmodule
bind vtd_top vtd_top_properties u_vtd_top_properties
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .hblank_in(hblank_in),
  .vblank_in(vblank_in), .active_video_in(active_video_in),
  .video_data_in(video_data_in), .hblank_out(hblank_out),
  .vblank_out(vblank_out), .active_video_out(active_video_out),
  .video_data_out(video_data_out)
);

// ### tb/vtd_sensor_model.sv
// image sensor model: free-running raster with blanking and active flag
`timescale 1ns/1ps
module vtd_sensor_model
#(
  parameter int TW = 20,
  parameter int TH = 12,
  parameter int HL = 3,
  parameter int HR = 16,
  parameter int VA = 9,
  parameter int AL = 5,
  parameter int AR = 12,
  parameter int AT = 2,
  parameter int AB = 6
)
(
  input wire pclk,
  input wire presetn,
  input wire h_style,
  input wire v_style,
  output logic hblank_in,
  output logic vblank_in,
  output logic active_video_in,
  output logic [11:0] video_data_in
);
  logic [7:0] col_reg; // raster column
  logic [7:0] row_reg; // raster line
  logic h_blank;
  logic v_blank;
  // one pixel per clock, frame origin at column 0 of line 0
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      col_reg <= 8'h00;
      row_reg <= 8'h00;
    end
    else if (col_reg == TW - 1)
    begin
      col_reg <= 8'h00;
      row_reg <= (row_reg == TH - 1) ? 8'h00 : row_reg + 8'h01;
    end
    else
      col_reg <= col_reg + 8'h01;
  end
  assign h_blank = col_reg < HL || col_reg > HR;
  assign v_blank = row_reg >= VA;
  // pins; valid style inverts blanking, active stays inside non-blank
  always @*
  begin
    hblank_in = h_blank ^ h_style;
    vblank_in = v_blank ^ v_style;
    active_video_in = !h_blank && !v_blank && row_reg >= AT &&
      row_reg <= AB && col_reg >= AL && col_reg <= AR;
    video_data_in = {row_reg[5:0], col_reg[5:0]};
  end
endmodule

// ### tb/video_timing_detector_bench.sv
// self-checking bench: measurements, polarity, generator, registers
`timescale 1ns/1ps
`include "vtd_regs.vh"
module video_timing_detector_bench;
  localparam int TW = 20; // clocks per line
  localparam int TH = 12; // lines per frame
  localparam int HL = 3; // first non-blank column
  localparam int HR = 16; // last non-blank column
  localparam int VA = 9; // non-blank lines
  localparam int AL = 5;
  localparam int AR = 12;
  localparam int AT = 2;
  localparam int AB = 6;
  localparam int FR = TW * TH; // clocks per frame
  localparam int HB = (TW - HR + HL - 1) * TH; // blanked clocks by line
  localparam int VB = (TH - VA) * TW; // blanked clocks by frame
  typedef struct {logic [11:0] a; logic [31:0] e;} vtd_row_t;
  vtd_row_t rows [9] = '{'{`VTD_TOTAL_COLS_OFS, TW},
    '{`VTD_TOTAL_ROWS_OFS, TH}, '{`VTD_BLANK_ROWS_OFS, TH - VA},
    '{`VTD_BLANK_LEFT_OFS, HL}, '{`VTD_BLANK_RIGHT_OFS, HR + 1},
    '{`VTD_ACT_LEFT_OFS, AL}, '{`VTD_ACT_RIGHT_OFS, AR},
    '{`VTD_ACT_TOP_OFS, AT}, '{`VTD_ACT_BOTTOM_OFS, AB}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic h_style = 1'b0; // sensor line signalling style
  logic v_style = 1'b0; // sensor frame signalling style
  wire [31:0] prdata;
  wire pready, pslverr, hblank_in, vblank_in, active_video_in;
  wire hblank_out, vblank_out, active_video_out;
  wire [11:0] video_data_in, video_data_out;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int hcnt, vcnt, acnt, vfall; // per-frame output tallies
  logic [31:0] q;
  always #5 pclk = ~pclk;
  vtd_top u_vtd_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hblank_in(hblank_in), .vblank_in(vblank_in),
    .active_video_in(active_video_in), .video_data_in(video_data_in),
    .hblank_out(hblank_out), .vblank_out(vblank_out),
    .active_video_out(active_video_out), .video_data_out(video_data_out));
  vtd_sensor_model #(.TW(TW), .TH(TH), .HL(HL), .HR(HR), .VA(VA), .AL(AL),
    .AR(AR), .AT(AT), .AB(AB)) u_vtd_sensor_model (.pclk(pclk),
    .presetn(presetn), .h_style(h_style), .v_style(v_style),
    .hblank_in(hblank_in), .vblank_in(vblank_in),
    .active_video_in(active_video_in), .video_data_in(video_data_in));
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready seen high ends this wait; the bench timeout catches a hang
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string what, input logic [11:0] a,
    input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, q, exp);
  endtask
  // tally outputs over exactly one frame, sampled after the edge
  task automatic count_frame();
    logic v_prev;
    hcnt = 0;
    vcnt = 0;
    acnt = 0;
    vfall = 0;
    @(posedge pclk);
    #1;
    v_prev = vblank_out;
    repeat (FR)
    begin
      @(posedge pclk);
      #1;
      hcnt += (hblank_out === 1'b1);
      vcnt += (vblank_out === 1'b1);
      acnt += (active_video_out === 1'b1);
      vfall += (v_prev === 1'b1 && vblank_out === 1'b0);
      v_prev = vblank_out;
    end
  endtask
  // hang guard, ceiling well above the expected few thousand clocks
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl reset", `VTD_CTRL_OFS, `VTD_CTRL_RST);
    rd("gen right reset", `VTD_GEN_RIGHT_OFS, 32'h0000ffff);
    rd("gen bottom reset", `VTD_GEN_BOTTOM_OFS, 32'h0000ffff);
    rd("unmapped", 12'h03c, 32'h0);
    $display("test reset values done");
    // both mixed styles; auto detection must settle either way
    for (int s = 1; s <= 2; s++)
    begin
      h_style <= s[0];
      v_style <= s[1];
      repeat (4 * FR) @(posedge pclk);
      foreach (rows[i])
        rd("measure", rows[i].a, rows[i].e);
      apb(1'b0, `VTD_STATUS_OFS, 32'h0);
      check("status", {27'h0, q[4:0]}, {27'h0, 3'b111, s[1:0]});
      $display("test style %0d done", s);
    end
    // every fixed polarity code; sensor is now h blank, v valid
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, `VTD_CTRL_OFS, m);
      repeat (8) @(posedge pclk);
      count_frame();
      check("line blank", hcnt, m[0] ? FR - HB : HB);
      check("frame blank", vcnt, m[1] ? VB : FR - VB);
    end
    $display("test fixed polarity done");
    apb(1'b1, `VTD_GEN_LEFT_OFS, AL + 1);
    apb(1'b1, `VTD_GEN_RIGHT_OFS, AR);
    apb(1'b1, `VTD_GEN_TOP_OFS, AT);
    apb(1'b1, `VTD_GEN_BOTTOM_OFS, AB);
    apb(1'b1, `VTD_CTRL_OFS, 32'h0000000a);
    repeat (2 * FR) @(posedge pclk);
    count_frame();
    check("cropped active", acnt, (AB - AT + 1) * (AR - AL));
    check("frame starts", vfall, 1);
    $display("test generator done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl after reset", `VTD_CTRL_OFS, `VTD_CTRL_RST);
    $display("test second reset done");
    print_verdict();
  end
endmodule
